// ==== hdl/ppfl_pkg.sv ====
package ppfl_pkg;
   // ==========================================================
   // port widths
   localparam int PPFL_TRI_W = 8;
   localparam int PPFL_TWO_W = 3;
   localparam int PPFL_THREE_W = 8;
   localparam int PPFL_FOUR_W = 8;
   localparam int PPFL_FIVE_W = 7;

   // ==========================================================
   // values after reset
   localparam logic [7:0] PPFL_TRI_LATCH_RST = 8'h00;
   localparam logic [7:0] PPFL_TRI_DIR_RST = 8'h00;   // all inputs
   localparam logic [2:0] PPFL_TWO_LATCH_RST = 3'h7;
   localparam logic [7:0] PPFL_THREE_LATCH_RST = 8'hff;
   localparam logic [7:0] PPFL_FOUR_LATCH_RST = 8'hff;
   localparam logic [6:0] PPFL_FIVE_LATCH_RST = 7'h7f;

   // ==========================================================
   // bit positions of shared pins
   localparam int PPFL_ONE_IRQ0_BIT = 0;
   localparam int PPFL_ONE_IRQ1_BIT = 1;
   localparam int PPFL_ONE_IRQ2_BIT = 2;
   localparam int PPFL_ONE_DIV_BIT = 3;
   localparam int PPFL_ONE_PGEN_BIT = 4;
   localparam int PPFL_ONE_T2_BIT = 5;
   localparam int PPFL_TWO_IRQ5_BIT = 0;
   localparam int PPFL_TWO_OSCI_BIT = 1;
   localparam int PPFL_TWO_OSCO_BIT = 2;
   localparam int PPFL_FOUR_CLK_BIT = 5;
   localparam int PPFL_FOUR_RX_BIT = 6;
   localparam int PPFL_FOUR_TX_BIT = 7;
   localparam int PPFL_FIVE_IRQ3_BIT = 0;
   localparam int PPFL_FIVE_IRQ4_BIT = 1;
   localparam int PPFL_FIVE_PWD_BIT = 2;
   localparam int PPFL_FIVE_CLK_BIT = 4;
   localparam int PPFL_FIVE_RX_BIT = 5;
   localparam int PPFL_FIVE_TX_BIT = 6;
endpackage

// ==== hdl/ppfl_tri_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one eight-bit tri-state port with per-bit direction
module ppfl_tri_port (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic latch_wr,
   input wire logic [ppfl_pkg::PPFL_TRI_W-1:0] latch_wdata,
   input wire logic dir_wr,
   input wire logic [ppfl_pkg::PPFL_TRI_W-1:0] dir_wdata,
   input wire logic [ppfl_pkg::PPFL_TRI_W-1:0] alt_sel,
   input wire logic [ppfl_pkg::PPFL_TRI_W-1:0] alt_val,
   input wire logic [ppfl_pkg::PPFL_TRI_W-1:0] pin_in,
   output logic [ppfl_pkg::PPFL_TRI_W-1:0] pin_out,
   output logic [ppfl_pkg::PPFL_TRI_W-1:0] pin_oe,
   output logic [ppfl_pkg::PPFL_TRI_W-1:0] rdata
);
   import ppfl_pkg::*;

   logic [PPFL_TRI_W-1:0] latch_q;
   logic [PPFL_TRI_W-1:0] latch_d;
   logic [PPFL_TRI_W-1:0] dir_q;
   logic [PPFL_TRI_W-1:0] dir_d;
   logic [PPFL_TRI_W-1:0] out_d;

   assign latch_d = latch_wr ? latch_wdata : latch_q;
   assign dir_d = dir_wr ? dir_wdata : dir_q;
   // alternate output is gated by the latch, so a cleared latch holds the pin low
   assign out_d = latch_q & (~alt_sel | alt_val);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= PPFL_TRI_LATCH_RST;
         dir_q <= PPFL_TRI_DIR_RST;
         pin_out <= PPFL_TRI_LATCH_RST;
         pin_oe <= PPFL_TRI_DIR_RST;
         rdata <= PPFL_TRI_LATCH_RST;
      end else begin
         latch_q <= latch_d;
         dir_q <= dir_d;
         pin_out <= out_d;
         pin_oe <= dir_q;
         rdata <= pin_in;   // pins are synchronous to clk_sys
      end
   end
endmodule
`default_nettype wire

// ==== hdl/ppfl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppfl_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   // tri-state ports, index 0..3 = port zero, one, six, seven
   input wire logic port_zero_wr,
   input wire logic [7:0] port_zero_wdata,
   input wire logic port_zero_dir_wr,
   input wire logic [7:0] port_zero_dir_wdata,
   input wire logic [7:0] port_zero_in,
   output logic [7:0] port_zero_out,
   output logic [7:0] port_zero_oe,
   output logic [7:0] port_zero_rdata,
   input wire logic port_one_wr,
   input wire logic [7:0] port_one_wdata,
   input wire logic port_one_dir_wr,
   input wire logic [7:0] port_one_dir_wdata,
   input wire logic [7:0] port_one_in,
   output logic [7:0] port_one_out,
   output logic [7:0] port_one_oe,
   output logic [7:0] port_one_rdata,
   input wire logic port_six_wr,
   input wire logic [7:0] port_six_wdata,
   input wire logic port_six_dir_wr,
   input wire logic [7:0] port_six_dir_wdata,
   input wire logic [7:0] port_six_in,
   output logic [7:0] port_six_out,
   output logic [7:0] port_six_oe,
   output logic [7:0] port_six_rdata,
   input wire logic port_seven_wr,
   input wire logic [7:0] port_seven_wdata,
   input wire logic port_seven_dir_wr,
   input wire logic [7:0] port_seven_dir_wdata,
   input wire logic [7:0] port_seven_in,
   output logic [7:0] port_seven_out,
   output logic [7:0] port_seven_oe,
   output logic [7:0] port_seven_rdata,
   // latched ports
   input wire logic port_two_wr,
   input wire logic [2:0] port_two_wdata,
   input wire logic [2:0] port_two_in,
   output logic [2:0] port_two_out,
   output logic [2:0] port_two_oe,
   output logic [2:0] port_two_rdata,
   input wire logic port_three_wr,
   input wire logic [7:0] port_three_wdata,
   input wire logic [7:0] port_three_in,
   output logic [7:0] port_three_out,
   output logic [7:0] port_three_oe,
   output logic [7:0] port_three_rdata,
   input wire logic port_four_wr,
   input wire logic [7:0] port_four_wdata,
   input wire logic [7:0] port_four_in,
   output logic [7:0] port_four_out,
   output logic [7:0] port_four_oe,
   output logic [7:0] port_four_rdata,
   input wire logic port_five_wr,
   input wire logic [6:0] port_five_wdata,
   input wire logic [6:0] port_five_in,
   output logic [6:0] port_five_out,
   output logic [6:0] port_five_oe,
   output logic [6:0] port_five_rdata,
   // alternate outputs from peripherals and their enables
   input wire logic divider_en,
   input wire logic divider_out,
   input wire logic pulse_gen_en,
   input wire logic pulse_generator_out,
   input wire logic low_osc_en,
   input wire logic low_osc_out,
   input wire logic serial_a_tx_en,
   input wire logic serial_a_tx,
   input wire logic serial_a_clk_oe,
   input wire logic serial_a_clk_drv,
   input wire logic serial_b_tx_en,
   input wire logic serial_b_tx,
   input wire logic serial_b_clk_oe,
   input wire logic serial_b_clk_drv,
   input wire logic pwd_en,
   input wire logic pwm_sel,
   input wire logic pwm_out,
   input wire logic pdo_out,
   // alternate inputs to peripherals
   output logic ext_irq_zero,
   output logic ext_irq_one,
   output logic ext_irq_two,
   output logic timer_one_input,
   output logic timer_two_input,
   output logic ext_irq_three,
   output logic timer_three_input,
   output logic ext_irq_four,
   output logic timer_four_input,
   output logic ext_irq_five,
   output logic stop_release,
   output logic low_osc_in,
   output logic serial_a_rx,
   output logic serial_a_clk,
   output logic serial_b_rx,
   output logic serial_b_clk,
   // bidirectional reset pin
   input wire logic addr_trap,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic reset_pin_level
);
   import ppfl_pkg::*;

   // ==========================================================
   // latched-pin helper
   // a bit is pulled low when the latch is zero or a selected alternate gives zero
   function automatic logic [7:0] eff_val(input logic [7:0] latch, input logic [7:0] sel, input logic [7:0] alt);
      eff_val = latch & (~sel | alt);
   endfunction

   // ==========================================================
   // tri-state ports
   logic [7:0] one_alt_sel;
   logic [7:0] one_alt_val;

   // divider and pulse outputs gated by latch
   assign one_alt_sel = {3'h0, pulse_gen_en, divider_en, 3'h0};
   assign one_alt_val = {3'h0, pulse_generator_out, divider_out, 3'h0};

   ppfl_tri_port u_port_zero (
      .clk_sys(clk_sys), .rst_n(rst_n), .latch_wr(port_zero_wr), .latch_wdata(port_zero_wdata),
      .dir_wr(port_zero_dir_wr), .dir_wdata(port_zero_dir_wdata), .alt_sel(8'h00), .alt_val(8'h00),
      .pin_in(port_zero_in), .pin_out(port_zero_out), .pin_oe(port_zero_oe), .rdata(port_zero_rdata)
   );
   ppfl_tri_port u_port_one (
      .clk_sys(clk_sys), .rst_n(rst_n), .latch_wr(port_one_wr), .latch_wdata(port_one_wdata),
      .dir_wr(port_one_dir_wr), .dir_wdata(port_one_dir_wdata), .alt_sel(one_alt_sel), .alt_val(one_alt_val),
      .pin_in(port_one_in), .pin_out(port_one_out), .pin_oe(port_one_oe), .rdata(port_one_rdata)
   );
   ppfl_tri_port u_port_six (
      .clk_sys(clk_sys), .rst_n(rst_n), .latch_wr(port_six_wr), .latch_wdata(port_six_wdata),
      .dir_wr(port_six_dir_wr), .dir_wdata(port_six_dir_wdata), .alt_sel(8'h00), .alt_val(8'h00),
      .pin_in(port_six_in), .pin_out(port_six_out), .pin_oe(port_six_oe), .rdata(port_six_rdata)
   );
   ppfl_tri_port u_port_seven (
      .clk_sys(clk_sys), .rst_n(rst_n), .latch_wr(port_seven_wr), .latch_wdata(port_seven_wdata),
      .dir_wr(port_seven_dir_wr), .dir_wdata(port_seven_dir_wdata), .alt_sel(8'h00), .alt_val(8'h00),
      .pin_in(port_seven_in), .pin_out(port_seven_out), .pin_oe(port_seven_oe), .rdata(port_seven_rdata)
   );

   // ==========================================================
   // latched ports: output latches
   logic [2:0] two_latch_q;
   logic [7:0] three_latch_q;
   logic [7:0] four_latch_q;
   logic [6:0] five_latch_q;

   // high-current port latch; software keeps ones
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         two_latch_q <= PPFL_TWO_LATCH_RST;
         three_latch_q <= PPFL_THREE_LATCH_RST;
         four_latch_q <= PPFL_FOUR_LATCH_RST;
         five_latch_q <= PPFL_FIVE_LATCH_RST;
      end else begin
         if (port_two_wr) two_latch_q <= port_two_wdata;
         if (port_three_wr) three_latch_q <= port_three_wdata;
         if (port_four_wr) four_latch_q <= port_four_wdata;
         if (port_five_wr) five_latch_q <= port_five_wdata;
      end
   end

   // ==========================================================
   // latched ports: alternate output selection
   logic pwd_val;
   logic [7:0] two_sel;
   logic [7:0] two_alt;
   logic [7:0] four_sel;
   logic [7:0] four_alt;
   logic [7:0] five_sel;
   logic [7:0] five_alt;
   logic [7:0] two_eff;
   logic [7:0] three_eff;
   logic [7:0] four_eff;
   logic [7:0] five_eff;

   // pulse width or divider, same pin
   assign pwd_val = pwm_sel ? pwm_out : pdo_out;
   assign two_sel = {5'h00, low_osc_en, 2'h0};
   assign two_alt = {5'h00, low_osc_out, 2'h0};
   assign four_sel = {serial_b_tx_en, 1'b0, serial_b_clk_oe, 5'h00};
   assign four_alt = {serial_b_tx, 1'b0, serial_b_clk_drv, 5'h00};
   assign five_sel = {1'b0, serial_a_tx_en, 1'b0, serial_a_clk_oe, 1'b0, pwd_en, 2'h0};
   assign five_alt = {1'b0, serial_a_tx, 1'b0, serial_a_clk_drv, 1'b0, pwd_val, 2'h0};

   assign two_eff = eff_val({5'h00, two_latch_q}, two_sel, two_alt);
   assign three_eff = eff_val(three_latch_q, 8'h00, 8'h00);
   assign four_eff = eff_val(four_latch_q, four_sel, four_alt);
   assign five_eff = eff_val({1'b0, five_latch_q}, five_sel, five_alt);

   // ==========================================================
   // latched ports: pin drivers and read-back, all registered
   // sink-only drive: a one is never forced, so a board signal can override it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port_two_out <= 3'h0;
         port_two_oe <= 3'h0;
         port_three_out <= 8'h00;
         port_three_oe <= 8'h00;
         port_four_out <= 8'h00;
         port_four_oe <= 8'h00;
         port_five_out <= 7'h00;
         port_five_oe <= 7'h00;
         port_two_rdata <= 3'h0;
         port_three_rdata <= 8'h00;
         port_four_rdata <= 8'h00;
         port_five_rdata <= 7'h00;
      end else begin
         port_two_out <= 3'h0;
         port_two_oe <= ~two_eff[2:0];
         port_three_out <= 8'h00;
         port_three_oe <= ~three_eff;
         port_four_out <= 8'h00;
         port_four_oe <= ~four_eff;
         port_five_out <= 7'h00;
         port_five_oe <= ~five_eff[6:0];
         port_two_rdata <= port_two_in;
         port_three_rdata <= port_three_in;
         port_four_rdata <= port_four_in;
         port_five_rdata <= port_five_in;
      end
   end

   // ==========================================================
   // alternate inputs, sampled from the pins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_zero <= 1'b0;
         ext_irq_one <= 1'b0;
         ext_irq_two <= 1'b0;
         timer_one_input <= 1'b0;
         timer_two_input <= 1'b0;
         ext_irq_three <= 1'b0;
         timer_three_input <= 1'b0;
         ext_irq_four <= 1'b0;
         timer_four_input <= 1'b0;
         ext_irq_five <= 1'b0;
         stop_release <= 1'b0;
         low_osc_in <= 1'b0;
         serial_a_rx <= 1'b0;
         serial_a_clk <= 1'b0;
         serial_b_rx <= 1'b0;
         serial_b_clk <= 1'b0;
      end else begin
         ext_irq_zero <= port_one_in[PPFL_ONE_IRQ0_BIT];
         ext_irq_one <= port_one_in[PPFL_ONE_IRQ1_BIT];
         // shared irq two / timer one pin
         ext_irq_two <= port_one_in[PPFL_ONE_IRQ2_BIT];
         timer_one_input <= port_one_in[PPFL_ONE_IRQ2_BIT];
         timer_two_input <= port_one_in[PPFL_ONE_T2_BIT];
         ext_irq_three <= port_five_in[PPFL_FIVE_IRQ3_BIT];
         timer_three_input <= port_five_in[PPFL_FIVE_IRQ3_BIT];
         ext_irq_four <= port_five_in[PPFL_FIVE_IRQ4_BIT];
         timer_four_input <= port_five_in[PPFL_FIVE_IRQ4_BIT];
         ext_irq_five <= port_two_in[PPFL_TWO_IRQ5_BIT];
         stop_release <= port_two_in[PPFL_TWO_IRQ5_BIT];
         low_osc_in <= port_two_in[PPFL_TWO_OSCI_BIT];
         serial_a_rx <= port_five_in[PPFL_FIVE_RX_BIT];
         serial_a_clk <= port_five_in[PPFL_FIVE_CLK_BIT];
         serial_b_rx <= port_four_in[PPFL_FOUR_RX_BIT];
         serial_b_clk <= port_four_in[PPFL_FOUR_CLK_BIT];
      end
   end

   // ==========================================================
   // reset pin: open drain, pulled low for the trap
   // drive low during address trap
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
         reset_pin_level <= 1'b0;
      end else begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= addr_trap;
         reset_pin_level <= reset_pin_in;
      end
   end
endmodule
`default_nettype wire

// ==== verification/ppfl_board.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// board side: pull-ups on every line, optional external drivers
module ppfl_board #(parameter int W = 59) (
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin_in
);
   // a released line follows its external driver when ext_en is set, else is pulled high; the device wins while it drives
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule
`default_nettype wire

// ==== verification/ppfl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port pin checker
module ppfl_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic port_zero_dir_wr,
   input wire logic [7:0] port_zero_dir_wdata,
   input wire logic port_zero_wr,
   input wire logic [7:0] port_zero_wdata,
   input wire logic [7:0] port_zero_out,
   input wire logic [7:0] port_zero_oe,
   input wire logic [7:0] port_one_oe,
   input wire logic [7:0] port_six_oe,
   input wire logic [7:0] port_seven_oe,
   input wire logic [7:0] port_one_in,
   input wire logic [2:0] port_two_in,
   input wire logic [2:0] port_two_out,
   input wire logic port_three_wr,
   input wire logic [7:0] port_three_wdata,
   input wire logic [7:0] port_three_oe,
   input wire logic [7:0] port_three_out,
   input wire logic [7:0] port_four_out,
   input wire logic [6:0] port_five_out,
   input wire logic [6:0] port_five_oe,
   input wire logic pwd_en,
   input wire logic pwm_sel,
   input wire logic pwm_out,
   input wire logic pdo_out,
   input wire logic ext_irq_five,
   input wire logic stop_release,
   input wire logic ext_irq_two,
   input wire logic timer_one_input,
   input wire logic addr_trap,
   input wire logic reset_pin_oe,
   input wire logic reset_pin_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_dir; port_zero_dir_wr |-> ##2 port_zero_oe == $past(port_zero_dir_wdata, 2); endproperty
   a_dir: assert property (p_dir) else $error("direction not applied");
   property p_out; port_zero_wr |-> ##2 (port_zero_out & port_zero_oe) == ($past(port_zero_wdata, 2) & port_zero_oe);
   endproperty
   a_out: assert property (p_out) else $error("latch not driven");
   property p_rst; disable iff (1'b0) !rst_n |-> (port_zero_oe | port_one_oe | port_six_oe | port_seven_oe) == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("tri bit driven in reset");
   property p_lat; port_three_wr |-> ##2 port_three_oe == ~$past(port_three_wdata, 2); endproperty
   a_lat: assert property (p_lat) else $error("latched pin wrong");
   property p_sink; port_two_out == 3'h0 && port_three_out == 8'h00 && port_four_out == 8'h00 && port_five_out == 7'h00;
   endproperty
   a_sink: assert property (p_sink) else $error("latched pin driven high");
   property p_irq5; $past(rst_n) |-> ext_irq_five == $past(port_two_in[0]) && stop_release == $past(port_two_in[0]);
   endproperty
   a_irq5: assert property (p_irq5) else $error("shared irq five pin");
   property p_irq2; $past(rst_n) |-> ext_irq_two == $past(port_one_in[2]) && timer_one_input == $past(port_one_in[2]);
   endproperty
   a_irq2: assert property (p_irq2) else $error("shared irq two pin");
   property p_pwd; $past(rst_n) && $past(pwd_en) && !$past(pwm_sel ? pwm_out : pdo_out) |-> port_five_oe[2];
   endproperty
   a_pwd: assert property (p_pwd) else $error("pwm or divider low missing");
   property p_trap; $past(rst_n) |-> reset_pin_oe == $past(addr_trap) && !reset_pin_out; endproperty
   a_trap: assert property (p_trap) else $error("reset pin not pulled");
endmodule
`default_nettype wire
bind ppfl_top ppfl_checker u_chk (.*);

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ppfl_pkg::*;
   logic clk_sys = 0, rst_n = 1, v = 0, addr_trap = 0;
   logic port_zero_wr = 0, port_zero_dir_wr = 0, port_one_wr = 0, port_one_dir_wr = 0, port_six_wr = 0;
   logic port_six_dir_wr = 0, port_seven_wr = 0, port_seven_dir_wr = 0, port_two_wr = 0, port_three_wr = 0;
   logic port_four_wr = 0, port_five_wr = 0, divider_en = 0, divider_out = 0, pulse_gen_en = 0;
   logic pulse_generator_out = 0, low_osc_en = 0, low_osc_out = 0, serial_a_tx_en = 0, serial_a_tx = 0;
   logic serial_a_clk_oe = 0, serial_a_clk_drv = 0, serial_b_tx_en = 0, serial_b_tx = 0, serial_b_clk_oe = 0;
   logic serial_b_clk_drv = 0, pwd_en = 0, pwm_sel = 0, pwm_out = 0, pdo_out = 0;
   logic ext_irq_zero, ext_irq_one, ext_irq_two, timer_one_input, timer_two_input, ext_irq_three;
   logic timer_three_input, ext_irq_four, timer_four_input, ext_irq_five, stop_release, low_osc_in;
   logic serial_a_rx, serial_a_clk, serial_b_rx, serial_b_clk, reset_pin_in, reset_pin_out;
   logic reset_pin_oe, reset_pin_level;
   logic [7:0] port_zero_wdata = 0, port_one_wdata = 0, port_six_wdata = 0, port_seven_wdata = 0;
   logic [7:0] port_zero_dir_wdata = 0, port_one_dir_wdata = 0, port_six_dir_wdata = 0, port_seven_dir_wdata = 0;
   logic [7:0] port_three_wdata = 0, port_four_wdata = 0, port_zero_in, port_one_in, port_six_in, port_seven_in;
   logic [7:0] port_three_in, port_four_in, port_zero_out, port_one_out, port_six_out, port_seven_out;
   logic [7:0] port_three_out, port_four_out, port_zero_oe, port_one_oe, port_six_oe, port_seven_oe;
   logic [7:0] port_three_oe, port_four_oe, port_zero_rdata, port_one_rdata, port_six_rdata, port_seven_rdata;
   logic [7:0] port_three_rdata, port_four_rdata;
   logic [2:0] port_two_wdata = 0, port_two_in, port_two_out, port_two_oe, port_two_rdata;
   logic [6:0] port_five_wdata = 0, port_five_in, port_five_out, port_five_oe, port_five_rdata;
   logic [58:0] ext_en = 0, ext_val = 0, pins;
   int bad_count = 0, total_checks = 0, cyc = 0;
   ppfl_top DUT (.*);
   ppfl_board u_board (.pin_out({reset_pin_out, port_zero_out, port_one_out, port_six_out, port_seven_out,
      port_two_out, port_three_out, port_four_out, port_five_out}), .pin_oe({reset_pin_oe, port_zero_oe,
      port_one_oe, port_six_oe, port_seven_oe, port_two_oe, port_three_oe, port_four_oe, port_five_oe}),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pins));
   assign {reset_pin_in, port_zero_in, port_one_in, port_six_in, port_seven_in, port_two_in, port_three_in,
      port_four_in, port_five_in} = pins;
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // all write strobes for one cycle, outputs settle two edges later
   task automatic wr_all(input logic [7:0] w, input logic [7:0] d);
      {port_zero_wdata, port_one_wdata, port_six_wdata, port_seven_wdata} = {4{w}};
      {port_zero_dir_wdata, port_one_dir_wdata, port_six_dir_wdata, port_seven_dir_wdata} = {4{d}};
      {port_zero_wr, port_one_wr, port_six_wr, port_seven_wr, port_zero_dir_wr, port_one_dir_wr} = '1;
      {port_six_dir_wr, port_seven_dir_wr, port_two_wr, port_three_wr, port_four_wr, port_five_wr} = '1;
      tick(1);
      {port_zero_wr, port_one_wr, port_six_wr, port_seven_wr, port_zero_dir_wr, port_one_dir_wr} = '0;
      {port_six_dir_wr, port_seven_dir_wr, port_two_wr, port_three_wr, port_four_wr, port_five_wr} = '0;
      tick(3);
   endtask
   // hang guard well above the expected 58 or so cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict;
      end
   end
   initial begin
      // a real falling edge, so the asynchronous reset loads every flop with its reset value before the first clock
      #1 rst_n = 0;
      tick(20);
      rst_n = 1;
      tick(3);
      chk(port_zero_oe | port_one_oe | port_six_oe | port_seven_oe, 8'h00);
      chk(port_three_rdata, 8'hff);
      // per-bit direction, latched port three sinks where latch is zero
      port_three_wdata = 8'h3c;
      port_two_wdata = 3'h7;
      port_four_wdata = 8'hff;
      port_five_wdata = 7'h7f;
      wr_all(8'ha5, 8'h0f);
      chk(port_seven_oe, 8'h0f);
      chk(port_one_out & port_one_oe, 8'h05);
      chk(port_zero_rdata, 8'hf5);
      chk(port_three_oe, 8'hc3);
      chk(port_three_rdata, 8'h3c);
      // alternates need the latch at one
      wr_all(8'hff, 8'h18);
      {divider_en, pulse_gen_en, low_osc_en, serial_a_tx_en, serial_a_clk_oe, serial_b_tx_en} = '1;
      {serial_b_clk_oe, pwd_en, pwm_sel} = '1;
      ext_en = '1;   // board drives every released line, so each alternate input toggles
      for (int i = 0; i < 2; i++) begin
         v = i[0];
         {divider_out, pulse_generator_out, low_osc_out, serial_a_tx, serial_a_clk_drv} = {5{v}};
         {serial_b_tx, serial_b_clk_drv, pwm_out} = {3{v}};
         ext_val = {59{v}};
         tick(4);
         chk(port_one_out[4:3], {2{v}});
         chk(port_two_oe, {~v, 2'b00});
         chk(port_four_oe, {~v, 1'b0, ~v, 5'h00});
         chk(port_five_oe, {~v, 1'b0, ~v, 1'b0, ~v, 2'b00});
         chk({ext_irq_five, stop_release}, {2{v}});
         chk({ext_irq_two, timer_one_input}, {2{v}});
         chk(serial_a_rx, v);
         chk({ext_irq_zero, ext_irq_one, timer_two_input}, {3{v}});
         chk({ext_irq_three, timer_three_input, ext_irq_four, timer_four_input, serial_a_clk}, {5{v}});
         chk({low_osc_in, port_two_rdata}, {4{v}});
         chk({serial_b_rx, serial_b_clk}, {2{v}});
         chk(port_four_rdata, {8{v}});
         chk(port_five_rdata, {7{v}});
         chk(port_one_rdata, {8{v}});
         chk(port_six_rdata, {{3{v}}, 2'b11, {3{v}}});
         chk(port_seven_rdata, {{3{v}}, 2'b11, {3{v}}});
         chk(port_three_rdata, {2'b00, {4{v}}, 2'b00});
      end
      pwm_sel = 0;
      tick(4);
      chk(port_five_oe, 7'h04);
      pdo_out = 1;
      tick(4);
      chk(port_five_oe, 7'h00);
      addr_trap = 1;
      tick(3);
      chk({reset_pin_oe, reset_pin_level}, 8'h02);
      addr_trap = 0;
      tick(3);
      chk(reset_pin_oe, 8'h00);
      // reset in mid-run drops every driver
      rst_n = 0;
      tick(2);
      chk(port_zero_oe | port_seven_oe | port_one_oe, 8'h00);
      rst_n = 1;
      tick(3);
      chk(port_three_oe, 8'h00);
      give_verdict;
   end
endmodule
`default_nettype wire
